/* verilog/spmc_ctrl.sv */
// sleep mode and power reduction controller
`include "spmc_regs.svh"

// How it works
// - idle gates core and program memory clocks
// - adc quiet also gates peripheral io clock
// - power-down stops oscillator and all clocks
// - wake holds core four cycles past startup
// - sleep never touches registers or memory
// - reset while asleep restarts from reset vector
// - idle wakes on any enabled interrupt
// - adc quiet wakes on restricted source set
// - power-down wakes on level, pin, watchdog
// - external zero wakes deep modes only level
// - enabled converter starts on idle/quiet entry
// - sleep-off at bit 7, resets zero
// - detector off after power-down entry, on at wake
// - detector-off wake uses reset startup delay
// - sleep-off writes need unlock sequence
// - unlock then write within four cycles
// - sleep-off active after three, clears later
// - reduction bit stops clock, blocks io access
// - clearing reduction bit resumes frozen state
// - per-peripheral stop matters in active/idle
// - converter enable survives every sleep mode
// - comparator off outside idle/quiet unless ref
// - fused detector stays on unless sw disabled
module spmc_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // core side
    input wire logic halt_op,
    input wire logic any_reset,
    output logic core_stall,
    output logic wake_irq_go,
    output logic restart_vector,
    // wake sources, already synchronous and enable-qualified
    input wire spmc_pkg::spmc_wake_s wake_src,
    // analog and fuse status
    input wire logic converter_enabled,
    input wire logic comparator_uses_ref,
    input wire logic detector_fuse_on,
    // clock gates and controls
    output spmc_pkg::spmc_clk_s clk_en,
    output logic [3:0] periph_clk_en,
    output logic [3:0] periph_access_ok,
    output logic converter_start,
    output logic comparator_auto_off,
    output logic detector_on,
    output logic asleep
);
    import spmc_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        spmc_state_e st;
        logic [7:0] ctrl;
        logic [3:0] pr;
        logic [2:0] unlock_cnt;
        logic [2:0] off_cnt;
        logic off_active;
        logic det_off;
        spmc_sel_e mode;
        logic [15:0] wait_cnt;
        logic conv_start;
        logic go;
        logic vec;
        logic [7:0] rdata;
    } spmc_state_s;

    spmc_state_s s_reg;
    spmc_state_s s_next;
    logic wake_hit;
    logic sel_ok;

    // ---------------------------------------------------------------
    // wake qualification per mode
    // ---------------------------------------------------------------
    always_comb begin
        wake_hit = 1'b0;
        case (s_reg.mode)
            SPMC_SEL_IDLE: begin
                wake_hit = |wake_src;
            end
            SPMC_SEL_ADC_QUIET: begin
                // edge mode on external zero ignored here
                wake_hit = wake_src.adc_done | wake_src.mem_ready |
                           wake_src.ext_zero_level |
                           wake_src.pin_change | wake_src.watchdog;
            end
            SPMC_SEL_POWER_DOWN: begin
                wake_hit = wake_src.ext_zero_level |
                           wake_src.pin_change | wake_src.watchdog;
            end
            default: begin
                wake_hit = 1'b0;
            end
        endcase
    end

    assign sel_ok = (s_reg.ctrl[`SPMC_BIT_SEL_HI:`SPMC_BIT_SEL_LO] != 2'b11);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.conv_start = 1'b0;
        s_next.go = 1'b0;
        s_next.vec = 1'b0;
        s_next.rdata = 8'h00;
        // sleep-off timing: active after delay, self-clears after hold
        if (s_reg.unlock_cnt != 3'h0) begin
            s_next.unlock_cnt = s_reg.unlock_cnt - 3'h1;
        end
        if (s_reg.ctrl[`SPMC_BIT_SLEEP_OFF]) begin
            if (s_reg.off_cnt == `SPMC_OFF_DELAY + `SPMC_OFF_HOLD - 3'h1) begin
                s_next.ctrl[`SPMC_BIT_SLEEP_OFF] = 1'b0;
                s_next.off_cnt = 3'h0;
                s_next.off_active = 1'b0;
            end else begin
                s_next.off_cnt = s_reg.off_cnt + 3'h1;
                s_next.off_active =
                    (s_reg.off_cnt + 3'h1 >= `SPMC_OFF_DELAY);
            end
        end
        // register writes; registers are never touched by sleep
        if (reg_wr) begin
            if (reg_addr == `SPMC_ADDR_CORE_CTRL) begin
                s_next.ctrl[6:0] = reg_wdata[6:0];
                s_next.ctrl[`SPMC_BIT_UNLOCK] = 1'b0;
                if (reg_wdata[`SPMC_BIT_SLEEP_OFF] &&
                    reg_wdata[`SPMC_BIT_UNLOCK]) begin
                    s_next.unlock_cnt = `SPMC_UNLOCK_WINDOW;
                    s_next.ctrl[`SPMC_BIT_UNLOCK] = 1'b1;
                end else if (reg_wdata[`SPMC_BIT_SLEEP_OFF] &&
                             s_reg.unlock_cnt != 3'h0) begin
                    s_next.ctrl[`SPMC_BIT_SLEEP_OFF] = 1'b1;
                    s_next.off_cnt = 3'h0;
                    s_next.off_active = 1'b0;
                    s_next.unlock_cnt = 3'h0;
                end
            end else if (reg_addr == `SPMC_ADDR_PWR_RED) begin
                // gated clocks freeze the peripheral, state is kept
                s_next.pr = reg_wdata[3:0];
            end
        end
        if (s_reg.unlock_cnt == 3'h1 && !(reg_wr &&
            reg_addr == `SPMC_ADDR_CORE_CTRL)) begin
            s_next.ctrl[`SPMC_BIT_UNLOCK] = 1'b0;
        end
        if (reg_rd) begin
            if (reg_addr == `SPMC_ADDR_CORE_CTRL) begin
                s_next.rdata = s_reg.ctrl;
            end else if (reg_addr == `SPMC_ADDR_PWR_RED) begin
                s_next.rdata = {4'h0, s_reg.pr};
            end else if (reg_addr == `SPMC_ADDR_STATUS) begin
                s_next.rdata = {4'h0, s_reg.det_off, 1'b0, s_reg.mode};
            end else begin
                s_next.rdata = 8'h00;
            end
        end
        case (s_reg.st)
            SPMC_ACTIVE: begin
                // halt with allow clear falls through as no-op
                if (halt_op && s_reg.ctrl[`SPMC_BIT_ALLOW] && sel_ok) begin
                    s_next.st = SPMC_SLEEP;
                    s_next.mode = spmc_sel_e'(
                        s_reg.ctrl[`SPMC_BIT_SEL_HI:`SPMC_BIT_SEL_LO]);
                    s_next.det_off = s_reg.off_active && s_reg.ctrl[4:3] ==
                        2'b10;
                    s_next.conv_start = converter_enabled &&
                        !s_reg.ctrl[`SPMC_BIT_SEL_HI];
                end
            end
            SPMC_SLEEP: begin
                if (wake_hit) begin
                    s_next.st = SPMC_WAKE;
                    s_next.det_off = 1'b0;
                    s_next.wait_cnt = (s_reg.det_off ?
                        `SPMC_RESET_STARTUP_CYC : `SPMC_STARTUP_CYC) +
                        16'(`SPMC_HALT_EXTRA);
                end
            end
            SPMC_WAKE: begin
                if (s_reg.wait_cnt <= 16'h0001) begin
                    s_next.st = SPMC_ACTIVE;
                    s_next.mode = SPMC_SEL_IDLE;
                    s_next.go = 1'b1;
                end else begin
                    s_next.wait_cnt = s_reg.wait_cnt - 16'h0001;
                end
            end
            default: begin
                s_next.st = SPMC_ACTIVE;
            end
        endcase
        // any reset while sleeping wins over wake sources
        if (any_reset && s_reg.st != SPMC_ACTIVE) begin
            s_next.st = SPMC_ACTIVE;
            s_next.mode = SPMC_SEL_IDLE;
            s_next.det_off = 1'b0;
            s_next.go = 1'b0;
            s_next.vec = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.st <= SPMC_ACTIVE;
            s_reg.mode <= SPMC_SEL_IDLE;
            s_reg.ctrl <= `SPMC_CORE_CTRL_RESET;
            s_reg.pr <= `SPMC_PWR_RED_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    logic sleeping;
    assign sleeping = (s_reg.st == SPMC_SLEEP);
    assign asleep = sleeping;
    assign reg_rdata = s_reg.rdata;
    assign core_stall = (s_reg.st != SPMC_ACTIVE);
    assign wake_irq_go = s_reg.go;
    assign restart_vector = s_reg.vec;
    assign converter_start = s_reg.conv_start;
    always_comb begin
        clk_en.core_clock = !sleeping;
        clk_en.program_memory_clock = !sleeping;
        clk_en.peripheral_io_clock = !(sleeping &&
            s_reg.mode != SPMC_SEL_IDLE);
        clk_en.converter_clock = !(sleeping &&
            s_reg.mode == SPMC_SEL_POWER_DOWN);
        clk_en.main_osc = clk_en.converter_clock;
    end
    // reduction bits gate the clock only where the io clock still runs
    assign periph_clk_en = ~s_reg.pr &
        {4{clk_en.peripheral_io_clock}};
    assign periph_access_ok = ~s_reg.pr;
    // converter enable is software owned; sleep never clears it
    assign comparator_auto_off = sleeping && !comparator_uses_ref &&
        s_reg.mode == SPMC_SEL_POWER_DOWN;
    assign detector_on = detector_fuse_on && !s_reg.det_off;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_idle_gates;
        @(posedge sys_clk) disable iff (!resetn)
        (sleeping && s_reg.mode == SPMC_SEL_IDLE) |->
            (!clk_en.core_clock && clk_en.peripheral_io_clock &&
             clk_en.main_osc);
    endproperty
    a_idle_gates: assert property (p_idle_gates)
        else $error("idle clock gating wrong");

    property p_quiet_gates;
        @(posedge sys_clk) disable iff (!resetn)
        (sleeping && s_reg.mode == SPMC_SEL_ADC_QUIET) |->
            (!clk_en.peripheral_io_clock && clk_en.converter_clock);
    endproperty
    a_quiet_gates: assert property (p_quiet_gates)
        else $error("adc quiet clock gating wrong");

    property p_down_gates;
        @(posedge sys_clk) disable iff (!resetn)
        (sleeping && s_reg.mode == SPMC_SEL_POWER_DOWN) |->
            (clk_en == '0);
    endproperty
    a_down_gates: assert property (p_down_gates)
        else $error("power-down left a clock running");

    property p_no_allow;
        @(posedge sys_clk) disable iff (!resetn)
        (s_reg.st == SPMC_ACTIVE && halt_op &&
         !s_reg.ctrl[`SPMC_BIT_ALLOW]) |=> !sleeping;
    endproperty
    a_no_allow: assert property (p_no_allow)
        else $error("slept without allow bit");

    property p_reserved;
        @(posedge sys_clk) disable iff (!resetn)
        (s_reg.st == SPMC_ACTIVE && halt_op && !sel_ok) |=> !sleeping;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("slept on reserved select");

    sequence s_wake_start;
        sleeping && wake_hit && !any_reset && !s_reg.det_off;
    endsequence
    // twenty stalled cycles: startup count plus the four halt cycles
    sequence s_stall_run;
        (core_stall && !sleeping) ##19 (core_stall && !wake_irq_go);
    endsequence
    sequence s_resume;
        wake_irq_go && !core_stall;
    endsequence
    property p_wake_delay;
        @(posedge sys_clk) disable iff (!resetn)
        s_wake_start |-> ##1 s_stall_run ##1 s_resume;
    endproperty
    a_wake_delay: assert property (p_wake_delay)
        else $error("wake stall not startup plus four");

    property p_reset_vec;
        @(posedge sys_clk) disable iff (!resetn)
        (any_reset && s_reg.st != SPMC_ACTIVE) |=>
            (restart_vector && !core_stall);
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset during sleep did not restart");

    property p_off_clear;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(s_reg.ctrl[`SPMC_BIT_SLEEP_OFF]) |->
            ##6 !s_reg.ctrl[`SPMC_BIT_SLEEP_OFF];
    endproperty
    a_off_clear: assert property (p_off_clear)
        else $error("sleep-off did not self-clear");

    property p_pd_wake;
        @(posedge sys_clk) disable iff (!resetn)
        (sleeping && s_reg.mode == SPMC_SEL_POWER_DOWN &&
         wake_src.other_io && !wake_src.watchdog &&
         !wake_src.pin_change && !wake_src.ext_zero_level && !any_reset)
            |=> sleeping;
    endproperty
    a_pd_wake: assert property (p_pd_wake)
        else $error("power-down woke on wrong source");

    property p_quiet_wake;
        @(posedge sys_clk) disable iff (!resetn)
        (sleeping && s_reg.mode == SPMC_SEL_ADC_QUIET && !any_reset &&
         !wake_src.adc_done && !wake_src.mem_ready &&
         !wake_src.ext_zero_level && !wake_src.pin_change &&
         !wake_src.watchdog) |=> sleeping;
    endproperty
    a_quiet_wake: assert property (p_quiet_wake)
        else $error("adc quiet woke on wrong source");

    property p_conv_start;
        @(posedge sys_clk) disable iff (!resetn)
        (s_reg.st == SPMC_ACTIVE && halt_op && sel_ok &&
         s_reg.ctrl[`SPMC_BIT_ALLOW] && !s_reg.ctrl[`SPMC_BIT_SEL_HI]) |=>
            (converter_start == $past(converter_enabled));
    endproperty
    a_conv_start: assert property (p_conv_start)
        else $error("converter start on entry wrong");

    property p_unlock_gate;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(s_reg.ctrl[`SPMC_BIT_SLEEP_OFF]) |->
            ($past(s_reg.unlock_cnt) != 3'h0);
    endproperty
    a_unlock_gate: assert property (p_unlock_gate)
        else $error("sleep-off set outside unlock window");

    property p_det_scope;
        @(posedge sys_clk) disable iff (!resetn)
        s_reg.det_off |-> (sleeping && s_reg.mode == SPMC_SEL_POWER_DOWN);
    endproperty
    a_det_scope: assert property (p_det_scope)
        else $error("detector off outside power-down sleep");

    property p_cmp_ref;
        @(posedge sys_clk) disable iff (!resetn)
        comparator_uses_ref |-> !comparator_auto_off;
    endproperty
    a_cmp_ref: assert property (p_cmp_ref)
        else $error("comparator switched off despite reference use");
endmodule : spmc_ctrl

/* verilog/spmc_regs.svh */
// register offsets, fields, reset values and timing counts
`ifndef SPMC_REGS_SVH
`define SPMC_REGS_SVH
`define SPMC_ADDR_CORE_CTRL 6'h35
`define SPMC_ADDR_PWR_RED 6'h00
`define SPMC_ADDR_STATUS 6'h3e
`define SPMC_CORE_CTRL_RESET 8'h00
`define SPMC_PWR_RED_RESET 4'h0
`define SPMC_BIT_SLEEP_OFF 7
`define SPMC_BIT_ALLOW 5
`define SPMC_BIT_SEL_HI 4
`define SPMC_BIT_SEL_LO 3
`define SPMC_BIT_UNLOCK 2
`define SPMC_UNLOCK_WINDOW 3'h4
`define SPMC_OFF_DELAY 3'h3
`define SPMC_OFF_HOLD 3'h3
`define SPMC_HALT_EXTRA 4'h4
`define SPMC_STARTUP_CYC 16'h0010
`define SPMC_RESET_STARTUP_CYC 16'h0400
`endif

/* verilog/spmc_pkg.sv */
// types shared by the sleep controller
package spmc_pkg;
    typedef enum logic [1:0] {
        SPMC_SEL_IDLE,
        SPMC_SEL_ADC_QUIET,
        SPMC_SEL_POWER_DOWN,
        SPMC_SEL_RESERVED
    } spmc_sel_e;
    typedef enum logic [1:0] {
        SPMC_ACTIVE,
        SPMC_SLEEP,
        SPMC_WAKE
    } spmc_state_e;
    // wake request lines from the interrupt system
    typedef struct packed {
        logic ext_zero_level;
        logic ext_zero_edge;
        logic pin_change;
        logic mem_ready;
        logic adc_done;
        logic other_io;
        logic watchdog;
    } spmc_wake_s;
    // clock gate enables toward the clock domains
    typedef struct packed {
        logic core_clock;
        logic program_memory_clock;
        logic peripheral_io_clock;
        logic converter_clock;
        logic main_osc;
    } spmc_clk_s;
endpackage : spmc_pkg

/* bench/spmc_core_model.sv */
// processor core model facing the sleep controller
module spmc_core_model (
    // clock
    input wire logic sys_clk,
    // controller answers
    input wire logic core_stall,
    input wire logic wake_irq_go,
    // halt request
    output logic halt_op
);
    timeunit 1ns;
    timeprecision 1ns;
    import spmc_pkg::*;
    int go_count;
    initial begin
        halt_op = 1'b0;
        go_count = 0;
    end
    // ------------------------------------------------------------
    // halt issue, one cycle, after the allow bit was written
    // ------------------------------------------------------------
    task automatic do_halt();
        @(posedge sys_clk);
        halt_op <= 1'b1;
        @(posedge sys_clk);
        halt_op <= 1'b0;
    endtask : do_halt
    // a stalled core never sees its service routine start early
    always @(posedge sys_clk) begin
        if (wake_irq_go === 1'b1 && core_stall === 1'b0) begin
            go_count <= go_count + 1;
        end
    end
endmodule : spmc_core_model

/* bench/sleep_mode_power_controller_tb.sv */
// self-checking bench for the sleep controller
`include "spmc_regs.svh"
module sleep_mode_power_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spmc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic halt_op, any_reset = 1'b0, core_stall, wake_irq_go;
    logic restart_vector, converter_start, comparator_auto_off;
    logic detector_on, asleep;
    logic conv_en = 1'b1, cmp_ref = 1'b0, fuse_on = 1'b1;
    logic [3:0] periph_clk_en, periph_access_ok;
    spmc_wake_s wake_src = '0;
    spmc_clk_s clk_en;
    int fail_count = 0, checked = 0, wakes = 0;
    logic [31:0] seed = 32'd85413;
    logic [4:0] exp_clk [3] = '{5'h07, 5'h03, 5'h00};
    logic [6:0] ign [3] = '{7'h00, 7'h22, 7'h2e};
    logic [6:0] wk [3] = '{7'h02, 7'h04, 7'h40};
    logic [7:0] cc;
    logic [3:0] pr;
    always #50 sys_clk = ~sys_clk;
    spmc_ctrl i_dut (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_op(halt_op),
        .any_reset(any_reset), .core_stall(core_stall),
        .wake_irq_go(wake_irq_go), .restart_vector(restart_vector),
        .wake_src(wake_src), .converter_enabled(conv_en),
        .comparator_uses_ref(cmp_ref), .detector_fuse_on(fuse_on),
        .clk_en(clk_en), .periph_clk_en(periph_clk_en),
        .periph_access_ok(periph_access_ok),
        .converter_start(converter_start),
        .comparator_auto_off(comparator_auto_off),
        .detector_on(detector_on), .asleep(asleep));
    spmc_core_model i_core (.sys_clk(sys_clk), .core_stall(core_stall),
        .wake_irq_go(wake_irq_go), .halt_op(halt_op));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp}, "read data");
    endtask : rd
    // stall cycles counted from the wake state up to the go pulse
    task automatic wait_go(input int exp);
        int n;
        int k;
        n = 0;
        for (k = 0; k < 2000; k++) begin
            @(posedge sys_clk);
            #1;
            if (wake_irq_go === 1'b1) break;
            if (core_stall === 1'b1 && asleep === 1'b0) n++;
        end
        if (k == 2000) begin
            fail_count++;
            final_report();
        end
        wakes++;
        chk(16'(n), 16'(exp), "wake stall length");
    endtask : wait_go
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({11'h0, clk_en}, 16'h1f, "reset clocks");
        chk({15'h0, asleep}, 16'h0, "reset asleep");
        rd(`SPMC_ADDR_CORE_CTRL, `SPMC_CORE_CTRL_RESET);
        rd(6'h10, 8'h00);
        $display("reset test done");
        // halt without allow, then reserved select
        wr(`SPMC_ADDR_CORE_CTRL, 8'h00);
        i_core.do_halt();
        repeat (2) @(posedge sys_clk);
        #1;
        chk({10'h0, asleep, clk_en}, 16'h1f, "halt without allow");
        wr(`SPMC_ADDR_CORE_CTRL, 8'h38);
        i_core.do_halt();
        repeat (2) @(posedge sys_clk);
        #1;
        chk({10'h0, asleep, clk_en}, 16'h1f, "reserved select");
        $display("no-sleep test done");
        // each mode: gating, ignored sources, wake and stall length
        for (int m = 0; m < 3; m++) begin
            cc = 8'h20 | {3'h0, 2'(m), 3'h0};
            wr(`SPMC_ADDR_CORE_CTRL, cc);
            conv_en <= (m != 0);
            i_core.do_halt();
            #1;
            chk({15'h0, asleep}, 16'h1, "entry");
            chk({11'h0, clk_en}, 16'(exp_clk[m]), "gate");
            chk({15'h0, converter_start}, 16'(m == 1), "auto start");
            chk({15'h0, comparator_auto_off}, 16'(m == 2), "cmp");
            chk({15'h0, detector_on}, 16'h1, "detector kept");
            @(posedge sys_clk);
            wake_src <= ign[m];
            repeat (6) @(posedge sys_clk);
            wake_src <= wk[m];
            #1;
            chk({15'h0, asleep}, 16'h1, "ignored");
            wait_go(`SPMC_STARTUP_CYC + `SPMC_HALT_EXTRA);
            wake_src <= '0;
            chk({11'h0, clk_en}, 16'h1f, "clocks back");
            rd(`SPMC_ADDR_CORE_CTRL, cc);
        end
        chk(16'(i_core.go_count), 16'(wakes), "go count");
        $display("mode test done");
        // reset while asleep
        wr(`SPMC_ADDR_CORE_CTRL, 8'h30);
        cmp_ref <= 1'b1;
        fuse_on <= 1'b0;
        i_core.do_halt();
        any_reset <= 1'b1;
        #1;
        chk({14'h0, asleep, comparator_auto_off}, 16'h2, "ref cmp");
        chk({15'h0, detector_on}, 16'h0, "fuse off");
        @(posedge sys_clk);
        any_reset <= 1'b0;
        cmp_ref <= 1'b0;
        fuse_on <= 1'b1;
        #1;
        chk({15'h0, restart_vector}, 16'h1, "restart vector");
        chk({15'h0, core_stall}, 16'h0, "stall after reset");
        $display("reset wake test done");
        // sleep-off sequence
        wr(`SPMC_ADDR_CORE_CTRL, 8'h80);
        rd(`SPMC_ADDR_CORE_CTRL, 8'h80 & 8'h00);
        wr(`SPMC_ADDR_CORE_CTRL, 8'h84);
        wr(`SPMC_ADDR_CORE_CTRL, 8'h80);
        rd(`SPMC_ADDR_CORE_CTRL, 8'h80);
        repeat (8) @(posedge sys_clk);
        rd(`SPMC_ADDR_CORE_CTRL, 8'h00);
        wr(`SPMC_ADDR_CORE_CTRL, 8'h84);
        wr(`SPMC_ADDR_CORE_CTRL, 8'hb0);
        // halt lands in the fourth cycle after set, inside the active window
        repeat (2) @(posedge sys_clk);
        i_core.do_halt();
        @(posedge sys_clk);
        wake_src <= 7'h10;
        #1;
        chk({14'h0, asleep, detector_on}, 16'h2, "detector off");
        wait_go(`SPMC_RESET_STARTUP_CYC + `SPMC_HALT_EXTRA);
        wake_src <= '0;
        chk({15'h0, detector_on}, 16'h1, "detector back");
        $display("sleep-off test done");
        // power reduction with random masks
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            pr = seed[3:0];
            wr(`SPMC_ADDR_PWR_RED, {4'h0, pr});
            rd(`SPMC_ADDR_PWR_RED, {4'h0, pr});
            chk({12'h0, periph_clk_en}, {12'h0, ~pr}, "clk");
            chk({12'h0, periph_access_ok}, {12'h0, ~pr}, "pr access");
        end
        $display("power reduction test done");
        final_report();
    end
endmodule : sleep_mode_power_controller_tb
